// ### rtl/pmc_pkg.sv
// constants and types for the power mode controller
package pmc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLK  = 8'h04;
    localparam logic [7:0] OFS_SENS = 8'h08;
    localparam logic [7:0] OFS_STBY = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_RETN = 8'h14;
    // control register fields
    localparam int CTRL_STBY_BIT  = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    // clock register fields
    localparam int CLK_EXT_BIT    = 0;
    localparam int CLK_CPU_LSB    = 4;
    localparam int CLK_TRIM_LSB   = 8;
    localparam int CLK_SDIV_LSB   = 16;
    localparam int CLK_PDIV_LSB   = 20;
    // standby enable register fields
    localparam int STBY_RTC_BIT   = 0;
    localparam int STBY_ALARM_BIT = 1;
    localparam int STBY_WKC_BIT   = 2;
    localparam int STBY_MASK_LSB  = 4;
    // status register fields
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_BOR_BIT   = 2;
    localparam int STAT_CAUSE_LSB = 8;
    // mode codes shown in status
    localparam logic [1:0] MODE_RUN_CODE   = 2'h0;
    localparam logic [1:0] MODE_STBY_CODE  = 2'h1;
    localparam logic [1:0] MODE_SLEEP_CODE = 2'h2;
    // reset values
    localparam logic [31:0] RST_CLK  = 32'h0011_8000;
    localparam logic [31:0] RST_SENS = 32'h0000_0000;
    localparam logic [31:0] RST_STBY = 32'h0000_0007;
    localparam logic [31:0] RST_RETN = 32'h0000_0000;
    // axi answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing
    localparam int CLK_MHZ          = 200;
    localparam int SUPPLY_SETTLE_NS = 2000;
    localparam int OSC_START_NS     = 5000;
    localparam int BOOT_RESET_NS    = 1000;
    localparam int SUPPLY_CYC = (SUPPLY_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_CYC    = (OSC_START_NS * CLK_MHZ + 999) / 1000;
    localparam int BOOT_CYC   = (BOOT_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W      = 16;

    typedef enum logic [2:0] {
        ST_RUN, ST_STBY_ENTER, ST_STBY, ST_STBY_SUPPLY, ST_STBY_OSC,
        ST_SLEEP, ST_SLEEP_WAKE
    } pm_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic       core_supply_en;
        logic       core_supply_low;
        logic       cpu_halt;
        logic       sys_reset;
        logic       osc_en;
        logic       clk_src_ext;
        logic [3:0] cpu_div;
        logic [7:0] osc_trim;
        logic       supervisor_en;
        logic       rtc_en;
        logic       alarm_en;
        logic       wake_ctrl_en;
    } pwr_ctl_t;
endpackage

// ### rtl/clk_div_tick.sv
// divides the system clock into a one-cycle tick for a clock domain
`timescale 1ns/100ps
module clk_div_tick #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    // control
    input  wire logic             run_in,
    input  wire logic [DIV_W-1:0] div_in,
    // tick
    output logic                  tick_out
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } div_state_t;

    div_state_t cur_ff;
    div_state_t nxt_st;

    generate
        if (DIV_W < 1 || DIV_W > 16) begin : g_bad
            $error("clk_div_tick: DIV_W out of range");
        end
    endgenerate

    // count up to the divisor and tick once per period
    always_comb begin
        nxt_st = cur_ff;
        nxt_st.tick = 1'b0;
        if (!run_in) begin
            nxt_st.cnt = '0;
        end else if (cur_ff.cnt >= div_in) begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = cur_ff.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign tick_out = cur_ff.tick;
endmodule // clk_div_tick

// ### rtl/power_mode_controller.sv
// run, standby and sleep sequencing with an axi4-lite register file
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - three modes only: run, standby with retention, sleep without execution
// - core supply regulator stays enabled throughout run mode
// - cpu clock picks internal oscillator or external source, 16 MHz max
// - software lowers clock by oscillator trim or clock divisors
// - dividers derive sensor and peripheral clocks from system clock
// - software enables each sensor interface component in run mode
// - from run, software requests only standby or sleep
// - entering standby halts the cpu while keeping its state
// - standby lowers core supply voltage instead of switching it off
// - all registers and sram are kept throughout standby
// - entering standby switches off all sensor components automatically
// - rtc, alarm and wake controller follow software enables in standby
// - entering standby stops the internal oscillator automatically
// - enabled alarm or any of four enabled wake events returns to run
// - standby wakes fast; sleep wake restarts the system
// - brown-out holds off code execution while supply is invalid
// - leaving sleep resets state and boots; retention register survives
// - power supervisor is off in sleep and standby
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter int N_WAKE  = 4,
    parameter int N_SENSE = 8
) (
    // clock and reset
    input  wire logic                   CLK_SYS_IN,
    input  wire logic                   RST_B_IN,
    // register bus
    input  wire pmc_pkg::axi_req_t      AXI_REQ_IN,
    output pmc_pkg::axi_rsp_t           AXI_RSP_OUT,
    // wake sources and supervision
    input  wire logic                   RTC_ALARM_IN,
    input  wire logic [N_WAKE-1:0]      WAKE_EVT_IN,
    input  wire logic                   BROWNOUT_IN,
    // power and clock controls
    output pmc_pkg::pwr_ctl_t           PWR_CTL_OUT,
    output logic [N_SENSE-1:0]          SENSOR_EN_OUT,
    output logic                        SENSOR_CLK_TICK_OUT,
    output logic                        PERIPH_CLK_TICK_OUT
);
    import pmc_pkg::*;

    typedef struct packed {
        pm_state_t         state;
        logic [CNT_W-1:0]  cnt;
        logic [31:0]       clk_reg;
        logic [31:0]       sens_reg;
        logic [31:0]       stby_reg;
        logic [31:0]       retn_reg;
        logic [N_WAKE:0]   cause;
        logic [N_WAKE-1:0] wake_s1;
        logic [N_WAKE-1:0] wake_s2;
        logic              alarm_s1;
        logic              alarm_s2;
        logic              bor_s1;
        logic              bor_s2;
        logic              aw_v;
        logic [7:0]        aw_a;
        logic              w_v;
        logic [31:0]       w_d;
        logic [3:0]        w_s;
        axi_rsp_t          rsp;
        pwr_ctl_t          pwr;
        logic [N_SENSE-1:0] sens_en;
    } pmc_state_t;

    pmc_state_t cur_ff;
    pmc_state_t nxt_st;
    logic       div_run;

    generate
        if (N_WAKE != 4 || N_SENSE < 1 || N_SENSE > 32) begin : g_bad
            $error("power_mode_controller: unsupported parameters");
        end
    endgenerate

    // merge write data into a register under byte strobes
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // mode code shown to software for a sequencer state
    function automatic logic [1:0] mode_code(input pm_state_t st);
        logic [1:0] m;
        case (st)
            ST_RUN:        m = MODE_RUN_CODE;
            ST_SLEEP,
            ST_SLEEP_WAKE: m = MODE_SLEEP_CODE;
            default:       m = MODE_STBY_CODE;
        endcase
        return m;
    endfunction

    // true for an offset the register file decodes
    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_CLK || a == OFS_SENS ||
               a == OFS_STBY || a == OFS_STAT || a == OFS_RETN;
    endfunction

    // next-state logic: bus slave, sequencer and outputs
    always_comb begin
        logic [N_WAKE:0] hit;
        logic            wake;
        logic            do_wr;
        logic [31:0]     rd;
        logic [31:0]     stat;
        hit   = '0;
        wake  = 1'b0;
        do_wr = 1'b0;
        rd    = '0;
        stat  = '0;
        nxt_st = cur_ff;

        // two-flop synchronisers for pin inputs
        nxt_st.wake_s1  = WAKE_EVT_IN;
        nxt_st.wake_s2  = cur_ff.wake_s1;
        nxt_st.alarm_s1 = RTC_ALARM_IN;
        nxt_st.alarm_s2 = cur_ff.alarm_s1;
        nxt_st.bor_s1   = BROWNOUT_IN;
        nxt_st.bor_s2   = cur_ff.bor_s1;

        // qualified wake sources
        if (cur_ff.stby_reg[STBY_WKC_BIT]) begin
            hit[N_WAKE-1:0] = cur_ff.wake_s2 &
                cur_ff.stby_reg[STBY_MASK_LSB +: N_WAKE];
        end
        hit[N_WAKE] = cur_ff.alarm_s2 & cur_ff.stby_reg[STBY_RTC_BIT] &
                      cur_ff.stby_reg[STBY_ALARM_BIT];
        wake = |hit;

        // write address and data are held in either order
        if (AXI_REQ_IN.awvalid && cur_ff.rsp.awready) begin
            nxt_st.aw_v = 1'b1;
            nxt_st.aw_a = AXI_REQ_IN.awaddr;
        end
        if (AXI_REQ_IN.wvalid && cur_ff.rsp.wready) begin
            nxt_st.w_v = 1'b1;
            nxt_st.w_d = AXI_REQ_IN.wdata;
            nxt_st.w_s = AXI_REQ_IN.wstrb;
        end
        if (cur_ff.rsp.bvalid && AXI_REQ_IN.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end
        do_wr = cur_ff.aw_v && cur_ff.w_v && !cur_ff.rsp.bvalid;
        if (do_wr) begin
            nxt_st.aw_v       = 1'b0;
            nxt_st.w_v        = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp  = is_mapped(cur_ff.aw_a) ? RESP_OKAY
                                                       : RESP_SLVERR;
            case (cur_ff.aw_a)
                OFS_CLK: begin
                    nxt_st.clk_reg = merge_strb(cur_ff.clk_reg,
                        cur_ff.w_d, cur_ff.w_s);
                end
                OFS_SENS: begin
                    nxt_st.sens_reg = merge_strb(cur_ff.sens_reg,
                        cur_ff.w_d, cur_ff.w_s);
                end
                OFS_STBY: begin
                    nxt_st.stby_reg = merge_strb(cur_ff.stby_reg,
                        cur_ff.w_d, cur_ff.w_s);
                end
                OFS_RETN: begin
                    nxt_st.retn_reg = merge_strb(cur_ff.retn_reg,
                        cur_ff.w_d, cur_ff.w_s);
                end
                OFS_STAT: begin
                    // write one clears a wake cause bit
                    if (cur_ff.w_s[1]) begin
                        nxt_st.cause = cur_ff.cause &
                            ~cur_ff.w_d[STAT_CAUSE_LSB +: N_WAKE+1];
                    end
                end
                default: begin
                end
            endcase
        end

        // mode requests are taken only in run mode
        if (do_wr && cur_ff.aw_a == OFS_CTRL && cur_ff.w_s[0] &&
            cur_ff.state == ST_RUN) begin
            if (cur_ff.w_d[CTRL_STBY_BIT]) begin
                nxt_st.state = ST_STBY_ENTER;
            end else if (cur_ff.w_d[CTRL_SLEEP_BIT]) begin
                nxt_st.state = ST_SLEEP;
            end
        end

        // read channel
        stat[STAT_MODE_LSB +: 2] = mode_code(cur_ff.state);
        stat[STAT_BOR_BIT] = cur_ff.bor_s2;
        stat[STAT_CAUSE_LSB +: N_WAKE+1] = cur_ff.cause;
        case (AXI_REQ_IN.araddr)
            OFS_CLK:  rd = cur_ff.clk_reg;
            OFS_SENS: rd = cur_ff.sens_reg;
            OFS_STBY: rd = cur_ff.stby_reg;
            OFS_STAT: rd = stat;
            OFS_RETN: rd = cur_ff.retn_reg;
            default:  rd = '0;
        endcase
        if (cur_ff.rsp.rvalid && AXI_REQ_IN.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
        end
        if (AXI_REQ_IN.arvalid && cur_ff.rsp.arready) begin
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rdata  = rd;
            nxt_st.rsp.rresp  = is_mapped(AXI_REQ_IN.araddr) ? RESP_OKAY
                                                             : RESP_SLVERR;
        end

        // mode sequencer
        if (cur_ff.cnt != '0) begin
            nxt_st.cnt = cur_ff.cnt - 1'b1;
        end
        case (cur_ff.state)
            ST_RUN: begin
            end
            ST_STBY_ENTER: begin
                // cpu already paused; now drop the supply and clocks
                nxt_st.state = ST_STBY;
            end
            ST_STBY: begin
                if (wake) begin
                    nxt_st.state = ST_STBY_SUPPLY;
                    nxt_st.cnt   = CNT_W'(SUPPLY_CYC);
                end
            end
            ST_STBY_SUPPLY: begin
                if (cur_ff.cnt == '0) begin
                    nxt_st.state = ST_STBY_OSC;
                    nxt_st.cnt   = CNT_W'(OSC_CYC);
                end
            end
            ST_STBY_OSC: begin
                if (cur_ff.cnt == '0) begin
                    nxt_st.state = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    nxt_st.state = ST_SLEEP_WAKE;
                    nxt_st.cnt   = CNT_W'(SUPPLY_CYC + OSC_CYC + BOOT_CYC);
                end
            end
            ST_SLEEP_WAKE: begin
                if (cur_ff.cnt == '0) begin
                    // system state restarts; retention register kept
                    nxt_st.state    = ST_RUN;
                    nxt_st.clk_reg  = RST_CLK;
                    nxt_st.sens_reg = RST_SENS;
                    nxt_st.stby_reg = RST_STBY;
                    nxt_st.aw_v     = 1'b0;
                    nxt_st.w_v      = 1'b0;
                end
            end
            default: begin
                nxt_st.state = ST_RUN;
            end
        endcase

        // wake causes are sticky; a new cause wins over a clear
        if (wake && (cur_ff.state == ST_STBY ||
                     cur_ff.state == ST_SLEEP)) begin
            nxt_st.cause = nxt_st.cause | hit;
        end

        // power controls follow the next state
        nxt_st.pwr.core_supply_en = nxt_st.state != ST_SLEEP;
        nxt_st.pwr.core_supply_low = nxt_st.state == ST_STBY;
        nxt_st.pwr.osc_en = !(nxt_st.state == ST_STBY ||
                              nxt_st.state == ST_STBY_SUPPLY ||
                              nxt_st.state == ST_SLEEP);
        nxt_st.pwr.cpu_halt = nxt_st.state != ST_RUN ||
                              cur_ff.bor_s2;
        nxt_st.pwr.sys_reset = nxt_st.state == ST_SLEEP ||
                               nxt_st.state == ST_SLEEP_WAKE;
        nxt_st.pwr.supervisor_en = !(nxt_st.state == ST_STBY ||
                                     nxt_st.state == ST_SLEEP);
        nxt_st.pwr.clk_src_ext = nxt_st.clk_reg[CLK_EXT_BIT];
        nxt_st.pwr.cpu_div  = nxt_st.clk_reg[CLK_CPU_LSB +: 4];
        nxt_st.pwr.osc_trim = nxt_st.clk_reg[CLK_TRIM_LSB +: 8];
        nxt_st.pwr.rtc_en   = nxt_st.stby_reg[STBY_RTC_BIT];
        nxt_st.pwr.alarm_en = nxt_st.stby_reg[STBY_ALARM_BIT];
        nxt_st.pwr.wake_ctrl_en = nxt_st.stby_reg[STBY_WKC_BIT];
        if (nxt_st.state == ST_RUN) begin
            nxt_st.sens_en = nxt_st.sens_reg[N_SENSE-1:0];
        end else begin
            nxt_st.sens_en = '0;
        end

        // bus readiness for the next cycle
        nxt_st.rsp.awready = !nxt_st.aw_v && !nxt_st.rsp.bvalid;
        nxt_st.rsp.wready  = !nxt_st.w_v && !nxt_st.rsp.bvalid;
        nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
    end

    // state register
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            cur_ff          <= '0;
            cur_ff.state    <= ST_RUN;
            cur_ff.clk_reg  <= RST_CLK;
            cur_ff.sens_reg <= RST_SENS;
            cur_ff.stby_reg <= RST_STBY;
            cur_ff.retn_reg <= RST_RETN;
            cur_ff.pwr.core_supply_en <= 1'b1;
            cur_ff.pwr.osc_en         <= 1'b1;
            cur_ff.pwr.supervisor_en  <= 1'b1;
            cur_ff.pwr.osc_trim <= RST_CLK[CLK_TRIM_LSB +: 8];
            cur_ff.pwr.cpu_div  <= RST_CLK[CLK_CPU_LSB +: 4];
            cur_ff.pwr.rtc_en   <= RST_STBY[STBY_RTC_BIT];
            cur_ff.pwr.alarm_en <= RST_STBY[STBY_ALARM_BIT];
            cur_ff.pwr.wake_ctrl_en <= RST_STBY[STBY_WKC_BIT];
            cur_ff.rsp.awready <= 1'b1;
            cur_ff.rsp.wready  <= 1'b1;
            cur_ff.rsp.arready <= 1'b1;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // derived clocks only run while the oscillator is up
    assign div_run = cur_ff.pwr.osc_en && !cur_ff.pwr.sys_reset;

    // sensor interface clock tick
    clk_div_tick #(
        .DIV_W (4)
    ) u_sens_div (
        .clk_in   (CLK_SYS_IN),
        .rst_b_in (RST_B_IN),
        .run_in   (div_run),
        .div_in   (cur_ff.clk_reg[CLK_SDIV_LSB +: 4]),
        .tick_out (SENSOR_CLK_TICK_OUT)
    );

    // peripheral clock tick
    clk_div_tick #(
        .DIV_W (4)
    ) u_peri_div (
        .clk_in   (CLK_SYS_IN),
        .rst_b_in (RST_B_IN),
        .run_in   (div_run),
        .div_in   (cur_ff.clk_reg[CLK_PDIV_LSB +: 4]),
        .tick_out (PERIPH_CLK_TICK_OUT)
    );

    // outputs straight from the state register
    assign AXI_RSP_OUT   = cur_ff.rsp;
    assign PWR_CTL_OUT   = cur_ff.pwr;
    assign SENSOR_EN_OUT = cur_ff.sens_en;
endmodule // power_mode_controller

// ### dv/pmc_monitor.sv
// concurrent checks on the power mode controller ports
`timescale 1ns/100ps
module pmc_monitor
    import pmc_pkg::*;
#(
    parameter int N_WAKE  = 4,
    parameter int N_SENSE = 8
) (
    // clock and reset
    input  wire logic               CLK_SYS_IN,
    input  wire logic               RST_B_IN,
    // sources
    input  wire logic               RTC_ALARM_IN,
    input  wire logic               BROWNOUT_IN,
    // controls
    input  wire pmc_pkg::pwr_ctl_t  PWR_CTL_OUT,
    input  wire logic [N_SENSE-1:0] SENSOR_EN_OUT
);
    // all checks on the system clock, off during reset
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_B_IN);

    a_run_supply_on: assert property (!PWR_CTL_OUT.cpu_halt &&
        !PWR_CTL_OUT.sys_reset |-> PWR_CTL_OUT.core_supply_en &&
        !PWR_CTL_OUT.core_supply_low) else $error("supply off in run");
    a_stby_supply_low: assert property (
        PWR_CTL_OUT.core_supply_low |->
        PWR_CTL_OUT.core_supply_en && !PWR_CTL_OUT.osc_en &&
        PWR_CTL_OUT.cpu_halt) else $error("bad standby levels");
    a_sensors_off_lowpower: assert property (
        (PWR_CTL_OUT.core_supply_low ||
        !PWR_CTL_OUT.core_supply_en) |-> SENSOR_EN_OUT == '0)
        else $error("sensor on in low power");
    a_supervisor_off: assert property (
        (PWR_CTL_OUT.core_supply_low ||
        !PWR_CTL_OUT.core_supply_en) |-> !PWR_CTL_OUT.supervisor_en)
        else $error("supervisor on in low power");
    a_sleep_holds_reset: assert property (
        !PWR_CTL_OUT.core_supply_en |->
        PWR_CTL_OUT.sys_reset) else $error("sleep without reset");
    a_boot_after_supply: assert property (
        $fell(PWR_CTL_OUT.sys_reset) |->
        $past(PWR_CTL_OUT.core_supply_en, 8)) else $error("boot too early");
    a_resume_order: assert property ($fell(PWR_CTL_OUT.cpu_halt) |->
        PWR_CTL_OUT.osc_en && PWR_CTL_OUT.core_supply_en &&
        !PWR_CTL_OUT.core_supply_low) else $error("resume before restore");
    a_brownout_halt: assert property (BROWNOUT_IN [*4] |->
        PWR_CTL_OUT.cpu_halt) else $error("runs in brownout");
    a_alarm_wakes: assert property (PWR_CTL_OUT.core_supply_low &&
        RTC_ALARM_IN && PWR_CTL_OUT.alarm_en && PWR_CTL_OUT.rtc_en |->
        ##[1:6] !PWR_CTL_OUT.core_supply_low) else $error("alarm missed");
endmodule // pmc_monitor

bind power_mode_controller pmc_monitor #(
    .N_WAKE (N_WAKE),
    .N_SENSE(N_SENSE)
) u_pmc_monitor (
    .CLK_SYS_IN   (CLK_SYS_IN),
    .RST_B_IN     (RST_B_IN),
    .RTC_ALARM_IN (RTC_ALARM_IN),
    .BROWNOUT_IN  (BROWNOUT_IN),
    .PWR_CTL_OUT  (PWR_CTL_OUT),
    .SENSOR_EN_OUT(SENSOR_EN_OUT)
);

// ### dv/wake_source.sv
// model of the wake event sources and the rtc alarm
`timescale 1ns/100ps
module wake_source (
    // clock
    input  wire logic       clk_in,
    // commands from the bench
    input  wire logic       alarm_req_in,
    input  wire logic [3:0] evt_req_in,
    // async levels toward the controller
    output logic            alarm_out,
    output logic [3:0]      evt_out
);
    // levels start quiet
    initial begin
        alarm_out = 1'b0;
        evt_out = 4'h0;
    end
    // change off the sampling edge, as a true async source would
    always @(negedge clk_in) begin
        alarm_out <= alarm_req_in;
        evt_out <= evt_req_in;
    end
endmodule // wake_source

// ### dv/power_mode_controller_test.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
module power_mode_controller_test;
    import pmc_pkg::*;
    logic       clk;
    logic       rst_b;
    axi_req_t   req;
    axi_rsp_t   rsp;
    logic       alarm_req;
    logic [3:0] evt_req;
    logic       alarm;
    logic [3:0] evt;
    logic       brown;
    pwr_ctl_t   pwr;
    logic [7:0] sens;
    logic       stick;
    logic       ptick;
    int         mismatches;
    int         num_checks;
    int         cs;
    int         cp;

    power_mode_controller dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
        .AXI_REQ_IN(req), .AXI_RSP_OUT(rsp), .RTC_ALARM_IN(alarm),
        .WAKE_EVT_IN(evt), .BROWNOUT_IN(brown), .PWR_CTL_OUT(pwr),
        .SENSOR_EN_OUT(sens), .SENSOR_CLK_TICK_OUT(stick),
        .PERIPH_CLK_TICK_OUT(ptick));
    wake_source ws (.clk_in(clk), .alarm_req_in(alarm_req),
        .evt_req_in(evt_req), .alarm_out(alarm), .evt_out(evt));

    // 200 MHz clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // compare, count and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic give_up;
        mismatches++;
        $display("wrong value at %0t: wait ran out", $time);
        end_of_test();
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // axi4-lite write: address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int t;
        t = 0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && t < 50);
        if (t >= 50) give_up();
        req.bready <= 1'b0;
        chk(rsp.bresp, er);
        @(posedge clk);
    endtask

    // axi4-lite read with expected data and response
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        int t;
        t = 0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && t < 50);
        if (t >= 50) give_up();
        req.rready <= 1'b0;
        chk(rsp.rdata, e);
        chk(rsp.rresp, er);
        @(posedge clk);
    endtask

    // wait for execution to resume, no sooner than lo cycles
    task automatic wait_run(input int lo);
        int t;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while ((pwr.cpu_halt !== 1'b0 || pwr.sys_reset !== 1'b0)
                   && t < 5000);
        if (t >= 5000) give_up();
        chk(t >= lo, 1);
    endtask

    // main sequence
    initial begin
        req = '0;
        alarm_req = 1'b0;
        evt_req = 4'h0;
        brown = 1'b0;
        rst_b = 1'b0;
        mismatches = 0;
        num_checks = 0;
        cyc(6);
        rst_b <= 1'b1;
        cyc(1);
        axi_rd(OFS_CLK, RST_CLK, RESP_OKAY);
        axi_rd(OFS_STBY, RST_STBY, RESP_OKAY);
        axi_rd(OFS_STAT, 32'h0, RESP_OKAY);
        chk({pwr.core_supply_en, pwr.osc_en,
             pwr.supervisor_en}, 3'h7);
        axi_rd(8'h18, 32'h0, RESP_SLVERR);
        axi_wr(8'h18, 32'h1, RESP_SLVERR);
        $display("test reset done");
        axi_wr(OFS_CLK, 32'h0042_4031, RESP_OKAY);
        axi_wr(OFS_SENS, 32'ha5, RESP_OKAY);
        cyc(2);
        chk({pwr.clk_src_ext, pwr.cpu_div,
             pwr.osc_trim}, 13'h1340);
        chk(sens, 8'ha5);
        cs = 0;
        cp = 0;
        repeat (60) begin
            @(posedge clk);
            cs += stick;
            cp += ptick;
        end
        chk(cs, 20);
        chk(cp, 12);
        $display("test clocks done");
        axi_wr(OFS_RETN, 32'h1234_5678, RESP_OKAY);
        axi_wr(OFS_STBY, 32'h27, RESP_OKAY);
        axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
        cyc(4);
        chk({pwr.cpu_halt, pwr.core_supply_en,
             pwr.core_supply_low, pwr.osc_en,
             pwr.supervisor_en, sens}, 13'h1c00);
        axi_rd(OFS_STAT, 32'h1, RESP_OKAY);
        evt_req <= 4'h1;
        cyc(30);
        chk(pwr.core_supply_low, 1);
        evt_req <= 4'h2;
        wait_run(SUPPLY_CYC + OSC_CYC);
        evt_req <= 4'h0;
        cyc(4);
        chk(sens, 8'ha5);
        axi_rd(OFS_RETN, 32'h1234_5678, RESP_OKAY);
        axi_rd(OFS_STAT, 32'h200, RESP_OKAY);
        $display("test standby done");
        for (int i = 0; i < 5; i++) begin
            axi_wr(OFS_STAT, 32'h1f00, RESP_OKAY);
            axi_wr(OFS_STBY, (i < 4) ? 32'hf4 : 32'h3, RESP_OKAY);
            axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
            cyc(4);
            chk({pwr.rtc_en, pwr.alarm_en, pwr.wake_ctrl_en},
                (i < 4) ? 3'h1 : 3'h6);
            if (i < 4) evt_req <= 4'h1 << i;
            else alarm_req <= 1'b1;
            wait_run(SUPPLY_CYC + OSC_CYC);
            evt_req <= 4'h0;
            alarm_req <= 1'b0;
            cyc(4);
            axi_rd(OFS_STAT, 32'h100 << i, RESP_OKAY);
        end
        $display("test wake sources done");
        axi_wr(OFS_CTRL, 32'h2, RESP_OKAY);
        cyc(4);
        chk({pwr.sys_reset, pwr.core_supply_en, pwr.osc_en,
             pwr.supervisor_en}, 4'h8);
        axi_rd(OFS_STAT, 32'h1002, RESP_OKAY);
        alarm_req <= 1'b1;
        wait_run(SUPPLY_CYC + OSC_CYC + BOOT_CYC);
        alarm_req <= 1'b0;
        cyc(4);
        axi_rd(OFS_CLK, RST_CLK, RESP_OKAY);
        axi_rd(OFS_SENS, RST_SENS, RESP_OKAY);
        axi_rd(OFS_RETN, 32'h1234_5678, RESP_OKAY);
        $display("test sleep done");
        axi_wr(OFS_STAT, 32'h1f00, RESP_OKAY);
        brown <= 1'b1;
        cyc(6);
        chk(pwr.cpu_halt, 1);
        axi_rd(OFS_STAT, 32'h4, RESP_OKAY);
        brown <= 1'b0;
        cyc(6);
        chk(pwr.cpu_halt, 0);
        $display("test brownout done");
        end_of_test();
    end
endmodule // power_mode_controller_test
